/* hdl/smx_pkg.sv */
//****************************************************************
// smx_pkg: shared constants for the serial memory aux commands
//****************************************************************
// Purpose: opcodes, field sizes, wake timing and state codes
// Assumes: core clock of 100 ns period
// Notes:   recovery counts derive from printed times
package smx_pkg;

  //**************************************************************
  // opcodes
  //**************************************************************
  // opcode values
  localparam logic [7:0] OP_ID_READ     = 8'h9f;
  localparam logic [7:0] OP_TAG_READ    = 8'h4c;
  localparam logic [7:0] OP_SN_WRITE    = 8'hc2;
  localparam logic [7:0] OP_SN_READ     = 8'hc3;
  localparam logic [7:0] OP_SEC_WRITE   = 8'h42;
  localparam logic [7:0] OP_SEC_READ    = 8'h4b;
  localparam logic [7:0] OP_SEC_FAST    = 8'h49;
  localparam logic [7:0] OP_DEEP_SLEEP  = 8'hba;
  localparam logic [7:0] OP_LOW_SLEEP   = 8'hb9;
  localparam logic [7:0] OP_LATCH_SET   = 8'h06;
  localparam logic [7:0] OP_LATCH_CLR   = 8'h04;

  //**************************************************************
  // bit counts (last bit index) and output lengths
  //**************************************************************
  localparam logic [6:0] LAST_BYTE  = 7'h07;
  localparam logic [6:0] LAST_ADDR  = 7'h0f;
  localparam logic [6:0] LAST_SN    = 7'h3f;
  localparam logic [6:0] LEN_ID     = 7'h20;
  localparam logic [6:0] LEN_TAG    = 7'h40;
  localparam logic [6:0] LEN_BYTE   = 7'h08;
  localparam logic [7:0] SEC_TOP    = 8'hff;
  localparam logic [63:0] SN_RESET  = 64'h0;

  //**************************************************************
  // protect range starts
  //**************************************************************
  localparam logic [15:0] PROT_QUARTER = 16'hc000;
  localparam logic [15:0] PROT_HALF    = 16'h8000;

  //**************************************************************
  // wake timing
  //**************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int DEEP_REC_US   = 10;
  localparam int LOW_REC_US    = 450;
  // longest times round down
  localparam int DEEP_REC_CYC  = (DEEP_REC_US * 1000) / CLK_PERIOD_NS;
  localparam int LOW_REC_CYC   = (LOW_REC_US * 1000) / CLK_PERIOD_NS;
  // pin sync, edge find, timer start and state step eat into the budget
  localparam int WAKE_LAG_CYC  = 5;

  //**************************************************************
  // command states
  //**************************************************************
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_ADDR  = 4'b0001,
    ST_DUMMY = 4'b0010,
    ST_SWR   = 4'b0011,
    ST_SNW   = 4'b0100,
    ST_OUT   = 4'b0101,
    ST_SLPRQ = 4'b0110,
    ST_SLEEP = 4'b0111,
    ST_WAKE  = 4'b1000,
    ST_DONE  = 4'b1001
  } smx_state_t;

endpackage

/* hdl/smx_sync.sv */
// Purpose: two-stage synchroniser for pin levels
// Assumes: inputs asynchronous to core_clk
// Notes:   first stage is read only by the second
`timescale 1ns/1ns
module smx_sync #(
  parameter int       W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinSync
);
  logic [W-1:0] stage1_reg;

  // two flops, reset to idle levels
  always_ff @(posedge core_clk) begin
    if (reset) begin
      stage1_reg <= INIT;
      pinSync    <= INIT;
    end else begin
      stage1_reg <= pinIn;
      pinSync    <= stage1_reg;
    end
  end
endmodule

/* hdl/smx_timer.sv */
// Purpose: wake recovery down-counter
// Assumes: start is a one-cycle pulse
// Notes:   done pulses once when COUNT cycles have passed
`timescale 1ns/1ns
module smx_timer #(
  parameter int COUNT = 100
) (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic start,
  output logic      done
);
  localparam int CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LOAD = CW'(COUNT);
  logic [CW-1:0] cnt_reg;

  // reload on start, pulse done on reaching one
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_reg <= '0;
      done    <= 1'b0;
    end else if (start) begin
      cnt_reg <= LOAD;
      done    <= 1'b0;
    end else begin
      done    <= (cnt_reg == CW'(1));
      if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - CW'(1);
      end
    end
  end
endmodule

/* hdl/smx_aux.sv */
// Purpose: serial memory slave for id, tag, serial number,
//          special sector, low-power modes and write protect
// Assumes: pins sampled by core_clk, link clock far slower
// Notes:   mode 0 and 3; data in on rising, out on falling
`timescale 1ns/1ns
module smx_aux
  import smx_pkg::*;
#(
  // identity values are arbitrary
  parameter logic [7:0]  MAKER_CODE   = 8'h5a,
  parameter logic [7:0]  CONT_CODE    = 8'h11,
  parameter logic [15:0] PRODUCT_CODE = 16'h1234,
  parameter logic [63:0] UNIQUE_TAG   = 64'h0123456789abcdef,
  parameter int          LOW_CYCLES   = LOW_REC_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        csN,
  input  wire logic        sck,
  input  wire logic        si,
  input  wire logic        wpN,
  input  wire logic        statusLockEnable,
  input  wire logic [1:0]  protectSize,
  input  wire logic [15:0] memAddr,
  output logic             soOut,
  output logic             soEnN,
  output logic             writeEnableLatch,
  output logic             memWriteAllowed,
  output logic             statusWriteAllowed,
  output logic             serialLocked,
  output logic             deepSleep,
  output logic             lowestSleep
);

  //**************************************************************
  // pin synchronisers and edges
  //**************************************************************
  logic [3:0] pinSync;
  logic       csPrev_reg;
  logic       sckPrev_reg;

  smx_sync #(
    .W    (4),
    .INIT (4'h9)
  ) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .pinIn    ({csN, sck, si, wpN}),
    .pinSync  (pinSync)
  );

  wire csNow   = pinSync[3];
  wire sckNow  = pinSync[2];
  wire siNow   = pinSync[1];
  wire wpNow   = pinSync[0];
  wire sckRise = sckNow & ~sckPrev_reg & ~csNow;
  wire sckFall = ~sckNow & sckPrev_reg & ~csNow;
  wire csFall  = ~csNow & csPrev_reg;

  // previous levels for edge finding
  always_ff @(posedge core_clk) begin
    if (reset) begin
      csPrev_reg  <= 1'b1;
      sckPrev_reg <= 1'b0;
    end else begin
      csPrev_reg  <= csNow;
      sckPrev_reg <= sckNow;
    end
  end

  //**************************************************************
  // state and storage
  //**************************************************************
  smx_state_t  state_reg;
  logic [6:0]  bitCnt_reg;
  logic [63:0] inShift_reg;
  logic [7:0]  opcode_reg;
  logic [7:0]  addr_reg;
  logic        pastTop_reg;
  logic [63:0] outShift_reg;
  logic [6:0]  outLeft_reg;
  logic        outFirst_reg;
  logic        sleepKind_reg;
  logic [63:0] sn_reg;
  logic [7:0]  sector [0:255];

  // decoded helpers
  wire [7:0]  newByte  = {inShift_reg[6:0], siNow};
  wire [63:0] newWord  = {inShift_reg[62:0], siNow};
  wire        secOut   = (opcode_reg == OP_SEC_READ) || (opcode_reg == OP_SEC_FAST);
  wire        atTop    = pastTop_reg || (addr_reg == SEC_TOP);
  wire [7:0]  nextAddr = addr_reg + 8'h01;
  wire [7:0]  nextByte = atTop ? 8'h00 : sector[nextAddr];
  wire        normal   = (state_reg != ST_SLPRQ) && (state_reg != ST_SLEEP) && (state_reg != ST_WAKE);
  wire        deepDone;
  wire        lowDone;
  wire        wakeDone = deepDone | lowDone;
  wire        deepGo   = (state_reg == ST_SLEEP) && csFall && !sleepKind_reg;
  wire        lowGo    = (state_reg == ST_SLEEP) && csFall && sleepKind_reg;

  // deep wake timer, less the pin-to-start lag
  smx_timer #(
    .COUNT (DEEP_REC_CYC - WAKE_LAG_CYC)
  ) u_deep_timer (
    .core_clk (core_clk),
    .reset    (reset),
    .start    (deepGo),
    .done     (deepDone)
  );

  // lowest wake timer, less the pin-to-start lag
  smx_timer #(
    .COUNT (LOW_CYCLES - WAKE_LAG_CYC)
  ) u_low_timer (
    .core_clk (core_clk),
    .reset    (reset),
    .start    (lowGo),
    .done     (lowDone)
  );

  //**************************************************************
  // command sequencer
  //**************************************************************
  // one process: a command walks opcode, address, data phases
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg        <= ST_IDLE;
      bitCnt_reg       <= 7'h00;
      inShift_reg      <= 64'h0;
      opcode_reg       <= 8'h00;
      addr_reg         <= 8'h00;
      pastTop_reg      <= 1'b0;
      outShift_reg     <= 64'h0;
      outLeft_reg      <= 7'h00;
      outFirst_reg     <= 1'b0;
      sleepKind_reg    <= 1'b0;
      soOut            <= 1'b0;
      soEnN            <= 1'b1;
      writeEnableLatch <= 1'b0;
      sn_reg           <= SN_RESET;
      serialLocked     <= 1'b0;
    end else if (csNow && normal) begin
      // deselect ends any command outside the sleep and wake states and floats the output
      state_reg   <= ST_IDLE;
      bitCnt_reg  <= 7'h00;
      pastTop_reg <= 1'b0;
      soEnN       <= 1'b1;
    end else if (csNow && (state_reg == ST_SLPRQ)) begin
      state_reg <= ST_SLEEP;
    end else begin
      if (sckRise) begin
        inShift_reg <= newWord;
        bitCnt_reg  <= bitCnt_reg + 7'h01;
      end
      case (state_reg)
        ST_IDLE: begin
          if (sckRise && bitCnt_reg == LAST_BYTE) begin
            opcode_reg   <= newByte;
            bitCnt_reg   <= 7'h00;
            outFirst_reg <= 1'b1;
            state_reg    <= ST_DONE;
            case (newByte)
              OP_ID_READ: begin
                outShift_reg <= {MAKER_CODE, CONT_CODE, PRODUCT_CODE, 32'h0};
                outLeft_reg  <= LEN_ID;
                state_reg    <= ST_OUT;
              end
              OP_TAG_READ: begin
                outShift_reg <= UNIQUE_TAG;
                outLeft_reg  <= LEN_TAG;
                state_reg    <= ST_OUT;
              end
              OP_SN_READ: begin
                outShift_reg <= sn_reg;
                outLeft_reg  <= LEN_TAG;
                state_reg    <= ST_OUT;
              end
              OP_SN_WRITE: state_reg <= ST_SNW;
              OP_SEC_WRITE,
              OP_SEC_READ,
              OP_SEC_FAST: state_reg <= ST_ADDR;
              OP_DEEP_SLEEP: begin
                sleepKind_reg <= 1'b0;
                state_reg     <= ST_SLPRQ;
              end
              OP_LOW_SLEEP: begin
                sleepKind_reg <= 1'b1;
                state_reg     <= ST_SLPRQ;
              end
              OP_LATCH_SET: writeEnableLatch <= 1'b1;
              OP_LATCH_CLR: writeEnableLatch <= 1'b0;
              default: state_reg <= ST_DONE;
            endcase
          end
        end
        ST_ADDR: begin
          if (sckRise && bitCnt_reg == LAST_ADDR) begin
            addr_reg   <= newByte;
            bitCnt_reg <= 7'h00;
            if (opcode_reg == OP_SEC_WRITE) begin
              state_reg <= ST_SWR;
            end else if (opcode_reg == OP_SEC_FAST) begin
              state_reg <= ST_DUMMY;
            end else begin
              outShift_reg <= {sector[newByte], 56'h0};
              outLeft_reg  <= LEN_BYTE;
              state_reg    <= ST_OUT;
            end
          end
        end
        ST_DUMMY: begin
          if (sckRise && bitCnt_reg == LAST_BYTE) begin
            bitCnt_reg   <= 7'h00;
            outShift_reg <= {sector[addr_reg], 56'h0};
            outLeft_reg  <= LEN_BYTE;
            state_reg    <= ST_OUT;
          end
        end
        ST_SWR: begin
          if (sckRise && bitCnt_reg == LAST_BYTE) begin
            bitCnt_reg <= 7'h00;
            if (addr_reg == SEC_TOP) begin
              pastTop_reg <= 1'b1;
            end else begin
              addr_reg <= nextAddr;
            end
          end
        end
        ST_SNW: begin
          if (sckRise && bitCnt_reg == LAST_SN) begin
            if (writeEnableLatch && !serialLocked) begin
              sn_reg       <= newWord;
              serialLocked <= 1'b1;
            end
            state_reg <= ST_DONE;
          end
        end
        ST_OUT: begin
          if (sckFall) begin
            soEnN <= 1'b0;
            if (outFirst_reg) begin
              outFirst_reg <= 1'b0;
              soOut        <= outShift_reg[63];
            end else if (outLeft_reg > 7'h01) begin
              outShift_reg <= {outShift_reg[62:0], 1'b0};
              outLeft_reg  <= outLeft_reg - 7'h01;
              soOut        <= outShift_reg[62];
            end else if (secOut) begin
              // next byte, zero once past top
              outShift_reg <= {nextByte, 56'h0};
              outLeft_reg  <= LEN_BYTE;
              soOut        <= nextByte[7];
              if (atTop) begin
                pastTop_reg <= 1'b1;
              end else begin
                addr_reg <= nextAddr;
              end
            end
          end
        end
        // a clock cancels the sleep request
        ST_SLPRQ: begin
          if (sckRise) begin
            state_reg <= ST_DONE;
          end
        end
        ST_SLEEP: begin
          soEnN <= 1'b1;
          if (csFall) begin
            state_reg <= ST_WAKE;
          end
        end
        // latch cleared on return to service
        ST_WAKE: begin
          if (wakeDone) begin
            writeEnableLatch <= 1'b0;
            state_reg        <= ST_DONE;
          end
        end
        default: state_reg <= state_reg;
      endcase
    end
  end

  //**************************************************************
  // sector array write port
  //**************************************************************
  // write at eighth data bit
  wire secWrite = (state_reg == ST_SWR) && !csNow && sckRise && (bitCnt_reg == LAST_BYTE) &&
                  writeEnableLatch && !pastTop_reg;

  // no reset on the array: it stands for retained cells
  always_ff @(posedge core_clk) begin
    if (secWrite) begin
      sector[addr_reg] <= newByte;
    end
  end

  //**************************************************************
  // protect decisions and status flags
  //**************************************************************
  // blocked range by protect size
  wire blocked = (protectSize == 2'b11) ||
                 (protectSize == 2'b10 && memAddr >= PROT_HALF) ||
                 (protectSize == 2'b01 && memAddr >= PROT_QUARTER);
  wire statusOk = writeEnableLatch && (!statusLockEnable || wpNow);

  // registered flags for the surrounding array logic
  always_ff @(posedge core_clk) begin
    if (reset) begin
      memWriteAllowed    <= 1'b0;
      statusWriteAllowed <= 1'b0;
      deepSleep          <= 1'b0;
      lowestSleep        <= 1'b0;
    end else begin
      memWriteAllowed    <= writeEnableLatch && !blocked;
      statusWriteAllowed <= statusOk;
      deepSleep          <= !normal && (state_reg != ST_SLPRQ) && !sleepKind_reg;
      lowestSleep        <= !normal && (state_reg != ST_SLPRQ) && sleepKind_reg;
    end
  end

  //**************************************************************
  // checks
  //**************************************************************
  localparam int DEEP_BOUND = DEEP_REC_CYC - WAKE_LAG_CYC + 2;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  chk_id_tail_hold: assert property (
    state_reg == ST_OUT && opcode_reg == OP_ID_READ && outLeft_reg == 7'h01 &&
    !outFirst_reg && !csNow |=> $stable(soOut))
    else $error("identity tail bit changed");

  chk_deep_float: assert property (
    state_reg == ST_SLEEP && !sleepKind_reg |=> soEnN)
    else $error("output driven in deep sleep");

  chk_low_float: assert property (
    state_reg == ST_SLEEP && sleepKind_reg |=> soEnN)
    else $error("output driven in lowest sleep");

  chk_sleep_cancel: assert property (
    state_reg == ST_SLPRQ && sckRise && !csNow |=> state_reg == ST_DONE)
    else $error("clock did not cancel sleep");

  chk_sleep_entry: assert property (
    state_reg == ST_SLPRQ && csNow |=> state_reg == ST_SLEEP ##1 deepSleep || lowestSleep)
    else $error("sleep not entered at deselect");

  chk_deep_wake: assert property (
    deepGo |-> ##[1:DEEP_BOUND] state_reg == ST_DONE)
    else $error("deep wake too slow");

  chk_serial_lock: assert property (
    serialLocked |=> $stable(sn_reg))
    else $error("locked serial number changed");

  chk_latch_needed: assert property (
    !writeEnableLatch && !serialLocked |=> sn_reg == $past(sn_reg) && !serialLocked)
    else $error("serial written without latch");

  chk_status_gate: assert property (
    statusLockEnable && !wpNow |=> !statusWriteAllowed)
    else $error("status write allowed while guarded");

  chk_protect_all: assert property (
    protectSize == 2'b11 ##1 protectSize == 2'b11 |-> !memWriteAllowed)
    else $error("write allowed with full protect");

endmodule

/* tb/smx_master.sv */
// Purpose: spi master model facing smx_aux
// Assumes: mode 0, sck idle low, 8 core cycles per bit
// Notes:   samples so mid high phase, where it stands still
`timescale 1ns/1ns
module smx_master (
  input  wire logic core_clk,
  input  wire logic soOut,
  input  wire logic soEnN,
  output logic      csN,
  output logic      sck,
  output logic      si
);
  // floating line shows the inverse, so a missed enable spoils the read
  wire soLine = soEnN ? ~soOut : soOut;

  initial begin
    csN = 1'b1;
    sck = 1'b0;
    si  = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // opcode and data clocks
  // one byte out and in, msb first
  task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si <= tx[i];
      wt(4);
      sck <= 1'b1;
      wt(2);
      rx[i] = soLine;
      wt(2);
      sck <= 1'b0;
    end
  endtask

  task automatic sel();
    csN <= 1'b0;
    wt(4);
  endtask

  // gap keeps deselect long enough
  task automatic desel();
    wt(4);
    csN <= 1'b1;
    wt(8);
  endtask

  // wake pulse; caller waits out recovery
  task automatic pulse();
    csN <= 1'b0;
    wt(2);
    csN <= 1'b1;
    wt(8);
  endtask
endmodule

/* tb/smx_aux_tb.sv */
// Purpose: self-checking bench for smx_aux
// Assumes: sck period 800 ns, core 100 ns
// Notes:   short lowest sleep recovery via LOW_CYCLES
`timescale 1ns/1ns
module smx_aux_tb;
  import smx_pkg::*;
  // ids are arbitrary
  localparam logic [31:0] ID_VAL  = 32'h5a111235;
  localparam logic [63:0] TAG_VAL = 64'h0123456789abcdef;
  localparam logic [63:0] SN1     = 64'hfeedc0de12345678;
  logic        core_clk, reset, wpN, statusLockEnable;
  logic        csN, sck, si, soOut, soEnN, writeEnableLatch;
  logic        memWriteAllowed, statusWriteAllowed;
  logic        serialLocked, deepSleep, lowestSleep;
  logic [1:0]  protectSize;
  logic [15:0] memAddr;
  logic [7:0]  rx;
  logic [63:0] v;
  int          n;
  int          num_errors = 0;
  int          total_checks = 0;
  logic [18:0] pTab [6] = '{19'h4ffff, 19'h5bfff, 19'h1c000, 19'h67fff, 19'h28000, 19'h30000};
  logic [2:0]  sTab [3] = '{3'b100, 3'b010, 3'b111};
  // recovery less the 10-cycle pulse, plus 2 for flag lag
  int          lim [2] = '{92, 42};
  logic [7:0]  sop [2] = '{OP_DEEP_SLEEP, OP_LOW_SLEEP};

  smx_aux #(
    .MAKER_CODE   (ID_VAL[31:24]),
    .CONT_CODE    (ID_VAL[23:16]),
    .PRODUCT_CODE (ID_VAL[15:0]),
    .UNIQUE_TAG   (TAG_VAL),
    .LOW_CYCLES   (50)
  ) u_dut (
    .core_clk(core_clk), .reset(reset), .csN(csN), .sck(sck), .si(si),
    .wpN(wpN), .statusLockEnable(statusLockEnable), .protectSize(protectSize),
    .memAddr(memAddr), .soOut(soOut), .soEnN(soEnN),
    .writeEnableLatch(writeEnableLatch), .memWriteAllowed(memWriteAllowed),
    .statusWriteAllowed(statusWriteAllowed), .serialLocked(serialLocked),
    .deepSleep(deepSleep), .lowestSleep(lowestSleep)
  );

  smx_master u_m (.core_clk(core_clk), .soOut(soOut), .soEnN(soEnN), .csN(csN), .sck(sck), .si(si));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  //****************************************************************
  // helpers
  //****************************************************************
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // bounded wait for both sleep flags to drop
  task automatic wait_low(input int lm);
    n = 0;
    while ((deepSleep | lowestSleep) !== 1'b0) begin
      @(posedge core_clk);
      n++;
      if (n > lm) begin
        num_errors++;
        finish_test();
      end
    end
  endtask

  task automatic op(input logic [7:0] c);
    u_m.sel();
    u_m.xb(c, rx);
  endtask

  task automatic cmd(input logic [7:0] c);
    op(c);
    u_m.desel();
  endtask

  // si changes every byte, device must not care
  task automatic rd(input int k);
    v = '0;
    for (int i = 0; i < k; i++) begin
      u_m.xb(8'h5a ^ i[7:0], rx);
      v = {v[55:0], rx};
    end
  endtask

  task automatic wr(input logic [63:0] d, input int k);
    for (int i = k - 1; i >= 0; i--) begin
      u_m.xb(d[8*i +: 8], rx);
    end
  endtask

  task automatic sn_check(input logic [63:0] exp);
    op(OP_SN_READ);
    rd(8);
    u_m.desel();
    check(v, exp);
  endtask

  //****************************************************************
  // main sequence
  //****************************************************************
  initial begin
    reset = 1'b1;
    wpN = 1'b1;
    statusLockEnable = 1'b0;
    protectSize = 2'h0;
    memAddr = 16'h0000;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    repeat (4) @(posedge core_clk);
    op(OP_ID_READ);
    rd(4);
    check(v[31:0], ID_VAL);
    rd(1);
    check(v[7:0], {8{ID_VAL[0]}});
    check(soEnN, 1'b0);
    u_m.desel();
    check(soEnN, 1'b1);
    op(OP_TAG_READ);
    rd(8);
    u_m.desel();
    check(v, TAG_VAL);
    sn_check(64'h0);
    op(OP_SN_WRITE);
    wr(SN1, 8);
    u_m.desel();
    check(serialLocked, 1'b0);
    sn_check(64'h0);
    cmd(OP_LATCH_SET);
    check(writeEnableLatch, 1'b1);
    op(OP_SN_WRITE);
    wr(SN1, 8);
    u_m.desel();
    check(serialLocked, 1'b1);
    sn_check(SN1);
    op(OP_SN_WRITE);
    wr(~SN1, 8);
    u_m.desel();
    sn_check(SN1);
    // known bottom byte shows that a write past top does not wrap
    op(OP_SEC_WRITE);
    wr(64'h000011, 3);
    u_m.desel();
    // upper address byte ignored, third byte past top dropped
    op(OP_SEC_WRITE);
    wr(64'habfea53c77, 5);
    u_m.desel();
    op(OP_SEC_READ);
    wr(64'h12fe, 2);
    rd(3);
    u_m.desel();
    check(v[23:0], 24'ha53c00);
    op(OP_SEC_READ);
    wr(64'hff00, 2);
    rd(1);
    u_m.desel();
    check(v[7:0], 8'h11);
    op(OP_SEC_FAST);
    wr(64'h00ff00, 3);
    rd(2);
    u_m.desel();
    check(v[15:0], 16'h3c00);
    // sleep entry, clocks ignored, wake, then cancel
    for (int k = 0; k < 2; k++) begin
      cmd(OP_LATCH_SET);
      cmd(sop[k]);
      check({lowestSleep, deepSleep}, k + 1);
      u_m.xb(OP_ID_READ, rx);
      check({lowestSleep, deepSleep, soEnN}, 2 * k + 3);
      u_m.pulse();
      wait_low(lim[k]);
      check(writeEnableLatch, 1'b0);
      op(sop[k]);
      u_m.xb(8'h00, rx);
      u_m.desel();
      check({lowestSleep, deepSleep}, 2'b00);
    end
    // latch clear after wake: sector write has no effect
    op(OP_SEC_WRITE);
    wr(64'h00fe99, 3);
    u_m.desel();
    op(OP_SEC_READ);
    wr(64'h00fe, 2);
    rd(1);
    u_m.desel();
    check(v[7:0], 8'ha5);
    cmd(OP_LATCH_SET);
    for (int i = 0; i < 6; i++) begin
      protectSize <= pTab[i][17:16];
      memAddr <= pTab[i][15:0];
      repeat (4) @(posedge core_clk);
      check(memWriteAllowed, pTab[i][18]);
    end
    // guard level moves only outside frames
    for (int i = 0; i < 3; i++) begin
      statusLockEnable <= sTab[i][1];
      wpN <= sTab[i][0];
      repeat (5) @(posedge core_clk);
      check(statusWriteAllowed, sTab[i][2]);
    end
    protectSize <= 2'h0;
    cmd(OP_LATCH_CLR);
    check({memWriteAllowed, statusWriteAllowed}, 2'b00);
    finish_test();
  end
endmodule
